// *** verilog/hsf_pkg.sv ***
// Constants, types and register map of the hot-swap fault sequencer.
`default_nettype none
package hsf_pkg;
  // Timebase and documented times.
  localparam int CLK_NS    = 100;
  localparam int OFF_MS    = 10;
  localparam int START_MS  = 150;
  localparam int FAULT_NS  = 4000;
  // Least times round up, the longest time rounds down.
  localparam int OFF_CYC   = (OFF_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int START_CYC = (START_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int FAULT_CYC = FAULT_NS / CLK_NS;
  localparam int CNT_W     = 21;
  // Register byte addresses.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MK = 8'h08;
  localparam logic [7:0] ADDR_CTRL   = 8'h0C;
  // Event bit positions in the interrupt status and mask registers.
  localparam int EV_TRIP  = 0;
  localparam int EV_THERM = 1;
  localparam int EV_UV    = 2;
  localparam int EV_OFF   = 3;
  localparam int EV_SUPPLY_OK_OUTPUT = 4;
  localparam int EV_W     = 5;
  localparam logic [EV_W-1:0] MASK_RST = 5'h00;
  localparam logic            CTRL_RST = 1'b0;
  typedef enum logic [1:0] {
    ST_WAIT  = 2'b00,
    ST_RAMP  = 2'b01,
    ST_ON    = 2'b10,
    ST_LATCH = 2'b11
  } hsf_state_t;
  typedef enum logic [1:0] {
    TRIP_300MV = 2'b00,
    TRIP_400MV = 2'b01,
    TRIP_500MV = 2'b10,
    TRIP_NONE  = 2'b11
  } hsf_trip_t;
  typedef enum logic {
    FAULT_RETRY = 1'b0,
    FAULT_LATCH = 1'b1
  } hsf_fault_t;
  // Comparator indications from the analog front end.
  typedef struct packed {
    logic enable_low;
    logic low_supply_lockout;
    logic over_temp;
    logic below_restart;
    logic drop_over_trip;
    logic fully_enhanced;
  } hsf_sense_t;
endpackage : hsf_pkg
`default_nettype wire

// *** verilog/hsf_sequencer.sv ***
// Hot-swap switch sequencing, fault handling and power-good logic with APB access.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module hsf_sequencer #(
  parameter hsf_pkg::hsf_trip_t  TRIP_SEL   = hsf_pkg::TRIP_400MV,
  parameter hsf_pkg::hsf_fault_t FAULT_MODE = hsf_pkg::FAULT_LATCH,
  parameter bit                  PG_ACT_LOW = 1'b1,
  parameter int                  START_CYC  = hsf_pkg::START_CYC,
  parameter int                  OFF_CYC    = hsf_pkg::OFF_CYC
) (
  // Clock and reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Comparator indications, asynchronous to pclk.
  input  wire hsf_pkg::hsf_sense_t sense_i,
  // Switch drive and comparator threshold select.
  output logic                    gate_on,
  output logic [1:0]              trip_threshold,
  // Open-drain power-good pin.
  output logic                    supply_ok_output_o,
  output logic                    supply_ok_output_oe,
  // Interrupt.
  output logic                    irq
);

  localparam int CW    = hsf_pkg::CNT_W;
  localparam int FRESP = hsf_pkg::FAULT_CYC;
  localparam logic [CW-1:0] START_LAST = CW'(START_CYC - 1);
  localparam logic [CW-1:0] OFF_FULL   = CW'(OFF_CYC);
  localparam bit   HAS_TRIP = (TRIP_SEL != hsf_pkg::TRIP_NONE);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchroniser: a change counts once stages two and three agree.

  hsf_pkg::hsf_sense_t s1_r, s2_r, s3_r, sf_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      sf_r <= '0;
    end else begin
      s1_r <= sense_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < $bits(hsf_pkg::hsf_sense_t); i++) begin
        if (s2_r[i] == s3_r[i]) sf_r[i] <= s3_r[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Thermal shutdown with hysteresis.

  logic therm_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      therm_r <= 1'b0;
    end else if (sf_r.over_temp) begin
      therm_r <= 1'b1;
    end else if (sf_r.below_restart) begin
      therm_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Turn-off filters for lockout and enable-low; both saturate at full count.

  logic [CW-1:0] uv_cnt_r, en_cnt_r;
  logic          uv_q, en_q;

  assign uv_q = (uv_cnt_r == OFF_FULL);
  assign en_q = (en_cnt_r == OFF_FULL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_cnt_r <= '0;
    end else if (!sf_r.low_supply_lockout) begin
      uv_cnt_r <= '0;
    end else if (!uv_q) begin
      uv_cnt_r <= uv_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_cnt_r <= '0;
    end else if (!sf_r.enable_low) begin
      en_cnt_r <= '0;
    end else if (!en_q) begin
      en_cnt_r <= en_cnt_r + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  hsf_pkg::hsf_state_t state_r, state_nxt;
  logic [CW-1:0]       start_cnt_r;
  logic                ctrl_off_r;
  logic                start_ok, soft_off, trip, pg_nxt, pg_r, gate_r;

  // Software off stops and blocks the switch like a held enable low, without the filter; it does not release the latch.
  assign start_ok = !sf_r.low_supply_lockout && !sf_r.enable_low
                    && !therm_r && !ctrl_off_r;
  assign soft_off = uv_q || en_q || ctrl_off_r;
  // The drop is only looked at once the switch is fully enhanced.
  assign trip = HAS_TRIP && (state_r == hsf_pkg::ST_ON)
                && sf_r.fully_enhanced && sf_r.drop_over_trip;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_cnt_r <= '0;
    end else if (state_r != hsf_pkg::ST_WAIT || !start_ok) begin
      start_cnt_r <= '0;
    end else if (start_cnt_r != START_LAST) begin
      start_cnt_r <= start_cnt_r + 1'b1;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      hsf_pkg::ST_WAIT: begin
        if (start_ok && start_cnt_r == START_LAST) state_nxt = hsf_pkg::ST_RAMP;
      end
      hsf_pkg::ST_RAMP: begin
        if (therm_r || soft_off) state_nxt = hsf_pkg::ST_WAIT;
        else if (sf_r.fully_enhanced) state_nxt = hsf_pkg::ST_ON;
      end
      hsf_pkg::ST_ON: begin
        if (therm_r) begin
          state_nxt = hsf_pkg::ST_WAIT;
        end else if (trip) begin
          state_nxt = (FAULT_MODE == hsf_pkg::FAULT_LATCH)
                      ? hsf_pkg::ST_LATCH : hsf_pkg::ST_WAIT;
        end else if (soft_off) begin
          state_nxt = hsf_pkg::ST_WAIT;
        end
      end
      hsf_pkg::ST_LATCH: begin
        if (en_q) state_nxt = hsf_pkg::ST_WAIT;
      end
      default: state_nxt = hsf_pkg::ST_WAIT;
    endcase
  end

  // Power-good follows the next state, so it falls in the same edge as the gate.
  assign pg_nxt = (state_nxt == hsf_pkg::ST_ON) && sf_r.fully_enhanced
                  && (!HAS_TRIP || !sf_r.drop_over_trip);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= hsf_pkg::ST_WAIT;
      gate_r  <= 1'b0;
      pg_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      gate_r  <= (state_nxt == hsf_pkg::ST_RAMP) || (state_nxt == hsf_pkg::ST_ON);
      pg_r    <= pg_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pins. The pull-down is on when the pin must read low.

  logic pg_oe_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Reads as not good while in reset, whichever polarity the build uses.
      pg_oe_r <= !PG_ACT_LOW;
    end else begin
      pg_oe_r <= PG_ACT_LOW ? pg_nxt : !pg_nxt;
    end
  end

  assign gate_on             = gate_r;
  assign trip_threshold      = TRIP_SEL;
  assign supply_ok_output_o  = 1'b0;
  assign supply_ok_output_oe = pg_oe_r;

  //////////////////////////////////////////////////////////////////////////////
  // Events and interrupt.

  logic [hsf_pkg::EV_W-1:0] ev, ist_r, imask_r, w1c;
  logic                     uv_q_d, en_q_d, therm_d;
  logic                     wr_en;

  assign wr_en = psel && penable && pwrite;
  assign w1c   = (wr_en && paddr == hsf_pkg::ADDR_IRQ_ST) ? pwdata[hsf_pkg::EV_W-1:0] : '0;

  always_comb begin
    ev                    = '0;
    ev[hsf_pkg::EV_TRIP]  = trip && state_nxt != hsf_pkg::ST_ON;
    ev[hsf_pkg::EV_THERM] = therm_r && !therm_d;
    ev[hsf_pkg::EV_UV]    = uv_q && !uv_q_d;
    ev[hsf_pkg::EV_OFF]   = en_q && !en_q_d;
    ev[hsf_pkg::EV_SUPPLY_OK_OUTPUT] = pg_nxt && !pg_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_q_d  <= 1'b0;
      en_q_d  <= 1'b0;
      therm_d <= 1'b0;
      ist_r   <= '0;
    end else begin
      uv_q_d  <= uv_q;
      en_q_d  <= en_q;
      therm_d <= therm_r;
      // A new event wins over a clear in the same cycle.
      ist_r   <= (ist_r & ~w1c) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((ist_r & ~w1c) | ev) & imask_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB registers; zero wait states, unmapped addresses answer with an error.

  logic mapped;

  always_comb begin
    mapped = 1'b1;
    prdata = '0;
    if (paddr == hsf_pkg::ADDR_STATUS) begin
      prdata[1:0] = state_r;
      prdata[2]   = gate_r;
      prdata[3]   = pg_r;
      prdata[4]   = therm_r;
      prdata[5]   = uv_q;
      prdata[6]   = en_q;
      prdata[13:8] = sf_r;
    end else if (paddr == hsf_pkg::ADDR_IRQ_ST) begin
      prdata[hsf_pkg::EV_W-1:0] = ist_r;
    end else if (paddr == hsf_pkg::ADDR_IRQ_MK) begin
      prdata[hsf_pkg::EV_W-1:0] = imask_r;
    end else if (paddr == hsf_pkg::ADDR_CTRL) begin
      prdata[0] = ctrl_off_r;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_r    <= hsf_pkg::MASK_RST;
      ctrl_off_r <= hsf_pkg::CTRL_RST;
    end else if (wr_en) begin
      if (paddr == hsf_pkg::ADDR_IRQ_MK) imask_r <= pwdata[hsf_pkg::EV_W-1:0];
      if (paddr == hsf_pkg::ADDR_CTRL) ctrl_off_r <= pwdata[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_therm_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
    therm_r |=> !gate_r)
    else $error("gate on during thermal shutdown");

  a_trip_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
    trip |=> !gate_r && !pg_r)
    else $error("gate or power-good stays on after trip");

  a_trip_enhanced: assert property (@(posedge pclk) disable iff (!presetn)
    trip |-> HAS_TRIP && sf_r.fully_enhanced)
    else $error("trip evaluated while not enhanced or disabled");

  a_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == hsf_pkg::ST_LATCH && !en_q |=> state_r == hsf_pkg::ST_LATCH && !gate_r)
    else $error("latched off state left without enable reset");

  a_start_wait: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(gate_r) |-> $past(start_cnt_r) == START_LAST && $past(start_ok))
    else $error("gate ramp began before the start wait");

  a_fault_resp: assert property (@(posedge pclk) disable iff (!presetn)
    sense_i.over_temp [*4] |-> ##[0:FRESP] !gate_r)
    else $error("over-temperature not answered in time");

  a_uv_filter: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(gate_r) && !$past(therm_r) && !$past(trip) && !$past(ctrl_off_r)
      |-> $past(uv_q) || $past(en_q))
    else $error("switch turned off without a qualified cause");

  a_pg_cause: assert property (@(posedge pclk) disable iff (!presetn)
    pg_r |-> gate_r && $past(sf_r.fully_enhanced))
    else $error("power-good without an enhanced switch");

  a_pg_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 supply_ok_output_oe == (PG_ACT_LOW ? pg_r : !pg_r))
    else $error("power-good pin polarity wrong");

  a_latch_entry: assert property (@(posedge pclk) disable iff (!presetn)
    FAULT_MODE == hsf_pkg::FAULT_LATCH && trip && !therm_r
      |=> state_r == hsf_pkg::ST_LATCH && !pg_r)
    else $error("latched build did not latch off after a trip");

  a_retry_rewait: assert property (@(posedge pclk) disable iff (!presetn)
    FAULT_MODE == hsf_pkg::FAULT_RETRY && trip
      |=> state_r == hsf_pkg::ST_WAIT && start_cnt_r == '0)
    else $error("retry build did not restart the start wait");

  a_start_block: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == hsf_pkg::ST_WAIT && !start_ok |=> !gate_r && start_cnt_r == '0)
    else $error("start wait ran without the start conditions");

  a_notrip_on: assert property (@(posedge pclk) disable iff (!presetn)
    !HAS_TRIP && state_r == hsf_pkg::ST_ON && !therm_r && !soft_off
      |=> state_r == hsf_pkg::ST_ON)
    else $error("no-trip build left the on state without a stop cause");

  a_on_holds: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == hsf_pkg::ST_ON && !therm_r && !trip && !soft_off |=> gate_r)
    else $error("switch turned off without a cause");

  a_filter_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !sf_r.low_supply_lockout && !sf_r.enable_low |=> uv_cnt_r == '0 && en_cnt_r == '0)
    else $error("turn-off filter not cleared when its condition broke");

  a_therm_release: assert property (@(posedge pclk) disable iff (!presetn)
    therm_r && !sf_r.over_temp && sf_r.below_restart |=> !therm_r)
    else $error("thermal shutdown not left below the restart limit");

  a_therm_hold: assert property (@(posedge pclk) disable iff (!presetn)
    therm_r && !sf_r.below_restart |=> therm_r)
    else $error("thermal shutdown left above the restart limit");

  a_soft_off_pg: assert property (@(posedge pclk) disable iff (!presetn)
    soft_off |=> !gate_r && !pg_r)
    else $error("switch or power-good on with a qualified off cause");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(ist_r & $past(imask_r)))
    else $error("interrupt level disagrees with masked status");

endmodule // hsf_sequencer
`default_nettype wire

// *** sim/hsf_switch_model.sv ***
// Behavioural model of the external pass switch and the pulled-up power-good line.
`timescale 1ns/10ps
`default_nettype none
module hsf_switch_model #(
  parameter int RAMP_CYC = 8
) (
  // Clock.
  input  wire logic pclk,
  // Device side.
  input  wire logic gate_on,
  input  wire logic pg_o,
  input  wire logic pg_oe,
  // Load control from the bench.
  input  wire logic overload,
  // Indications back to the device and the supervisor.
  output logic      fully_enhanced,
  output logic      drop_over_trip,
  output logic      pg_pin
);
  int ramp_r;
  // The gate charges over several cycles, so enhancement lags the turn-on.
  always_ff @(posedge pclk) begin
    if (!gate_on) begin
      ramp_r <= 0;
    end else if (ramp_r < RAMP_CYC) begin
      ramp_r <= ramp_r + 1;
    end
  end
  assign fully_enhanced = gate_on && (ramp_r == RAMP_CYC);
  // A switch that does not conduct shows no drop, whatever the load.
  assign drop_over_trip = fully_enhanced && overload;
  // The pin has a pull-up, so a released pin reads high.
  assign pg_pin = pg_oe ? pg_o : 1'b1;
endmodule // hsf_switch_model
`default_nettype wire

// *** sim/hot_swap_fault_sequencer_test.sv ***
// Self-checking testbench of the hot-swap fault sequencer.
`timescale 1ns/10ps
`default_nettype none
module hot_swap_fault_sequencer_test;
  localparam int START = 50;
  localparam int OFFC  = 20;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic                gate_on, pg_o, pg_oe, irq, overload, fe, dot, pg_pin;
  logic                en_low, lockout, hot, cool;
  logic [1:0]          trip_threshold;
  hsf_pkg::hsf_sense_t sense;
  int                  num_errors, cmp_count, cyc, n;
  // Second and third builds: auto-retry with active-high power-good, and no trip.
  logic                gate_rt, pgo_rt, pgoe_rt, fe_rt, dot_rt, pin_rt;
  logic                gate_nt, pgo_nt, pgoe_nt, fe_nt, dot_nt, pin_nt;
  logic [1:0]          thr_rt, thr_nt;
  hsf_pkg::hsf_sense_t sense_rt, sense_nt;
  assign sense = {en_low, lockout, hot, cool, dot, fe};
  assign sense_rt = {en_low, lockout, hot, cool, dot_rt, fe_rt};
  assign sense_nt = {en_low, lockout, hot, cool, dot_nt, fe_nt};
  hsf_sequencer #(.TRIP_SEL(hsf_pkg::TRIP_400MV), .FAULT_MODE(hsf_pkg::FAULT_LATCH),
    .PG_ACT_LOW(1'b1), .START_CYC(START), .OFF_CYC(OFFC)) hsf_sequencer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense_i(sense), .gate_on(gate_on), .trip_threshold(trip_threshold),
    .supply_ok_output_o(pg_o), .supply_ok_output_oe(pg_oe), .irq(irq));
  hsf_switch_model hsf_switch_model_i (.pclk(pclk), .gate_on(gate_on), .pg_o(pg_o),
    .pg_oe(pg_oe), .overload(overload), .fully_enhanced(fe), .drop_over_trip(dot),
    .pg_pin(pg_pin));
  hsf_sequencer #(.TRIP_SEL(hsf_pkg::TRIP_300MV), .FAULT_MODE(hsf_pkg::FAULT_RETRY),
    .PG_ACT_LOW(1'b0), .START_CYC(START), .OFF_CYC(OFFC)) hsf_sequencer_retry_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .sense_i(sense_rt), .gate_on(gate_rt), .trip_threshold(thr_rt),
    .supply_ok_output_o(pgo_rt), .supply_ok_output_oe(pgoe_rt), .irq());
  hsf_switch_model hsf_switch_model_retry_i (.pclk(pclk), .gate_on(gate_rt), .pg_o(pgo_rt),
    .pg_oe(pgoe_rt), .overload(overload), .fully_enhanced(fe_rt), .drop_over_trip(dot_rt),
    .pg_pin(pin_rt));
  hsf_sequencer #(.TRIP_SEL(hsf_pkg::TRIP_NONE), .FAULT_MODE(hsf_pkg::FAULT_LATCH),
    .PG_ACT_LOW(1'b1), .START_CYC(START), .OFF_CYC(OFFC)) hsf_sequencer_notrip_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .sense_i(sense_nt), .gate_on(gate_nt), .trip_threshold(thr_nt),
    .supply_ok_output_o(pgo_nt), .supply_ok_output_oe(pgoe_nt), .irq());
  hsf_switch_model hsf_switch_model_notrip_i (.pclk(pclk), .gate_on(gate_nt), .pg_o(pgo_nt),
    .pg_oe(pgoe_nt), .overload(overload), .fully_enhanced(fe_nt), .drop_over_trip(dot_nt),
    .pg_pin(pin_nt));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // A hang in a wait would otherwise never reach the report.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  // Equal bounds mean the gate must not reach v in fewer than that many cycles.
  task automatic gate_wait(input logic v, input int lo, input int hi, input string nm);
    logic ok;
    n = 0;
    while (gate_on !== v && n < hi) begin
      @(posedge pclk);
      n++;
    end
    ok = n >= lo && n <= hi && (gate_on === v || lo == hi);
    chk(nm, 32'h1, {31'h0, ok});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {en_low, lockout, hot, overload} = '0;
    {presetn, cool} = 2'b01;
    {num_errors, cmp_count, cyc} = '0;
    cycles(4);
    presetn <= 1'b1;
    chk("gate_rst", 32'h0, gate_on);
    chk("thr", hsf_pkg::TRIP_400MV, trip_threshold);
    chk("thr_rt", hsf_pkg::TRIP_300MV, thr_rt);
    chk("thr_nt", hsf_pkg::TRIP_NONE, thr_nt);
    gate_wait(1'b1, START, START + 20, "start_wait");
    rdreg(hsf_pkg::ADDR_IRQ_MK, 32'h1F, hsf_pkg::MASK_RST, "mask_rst");
    apb(1'b1, 8'h40, 32'h1);
    chk("slverr", 32'h1, err);
    apb(1'b1, hsf_pkg::ADDR_IRQ_MK, 32'h1F);
    cycles(20);
    chk("pg_on", 32'h0, pg_pin);
    chk("pg_on_rt", 32'h1, pin_rt);
    chk("pg_on_nt", 32'h0, pin_nt);
    chk("irq_pg", 32'h1, irq);
    rdreg(hsf_pkg::ADDR_IRQ_ST, 32'h10, 32'h10, "pg_event");
    apb(1'b1, hsf_pkg::ADDR_IRQ_ST, 32'h1F);
    cycles(2);
    chk("irq_clr", 32'h0, irq);
    overload <= 1'b1;
    gate_wait(1'b0, 0, 40, "trip_off");
    overload <= 1'b0;
    cycles(2);
    chk("pg_trip", 32'h1, pg_pin);
    chk("gate_trip_rt", 32'h0, gate_rt);
    chk("pg_trip_rt", 32'h0, pin_rt);
    chk("gate_trip_nt", 32'h1, gate_nt);
    chk("pg_trip_nt", 32'h0, pin_nt);
    chk("irq_trip", 32'h1, irq);
    rdreg(hsf_pkg::ADDR_STATUS, 32'h3, 32'h3, "latched");
    apb(1'b1, hsf_pkg::ADDR_IRQ_MK, 32'h0);
    cycles(2);
    chk("irq_mask", 32'h0, irq);
    chk("retry_hold", 32'h0, gate_rt);
    en_low <= 1'b1;
    cycles(OFFC / 2);
    en_low <= 1'b0;
    gate_wait(1'b1, START + 30, START + 30, "latch_hold");
    chk("retry_gate", 32'h1, gate_rt);
    chk("retry_pg", 32'h1, pin_rt);
    en_low <= 1'b1;
    cycles(OFFC + 10);
    en_low <= 1'b0;
    gate_wait(1'b1, START, START + 20, "latch_reset");
    cycles(20);
    lockout <= 1'b1;
    cycles(OFFC - 8);
    lockout <= 1'b0;
    gate_wait(1'b0, 40, 40, "uv_short");
    lockout <= 1'b1;
    gate_wait(1'b0, OFFC, OFFC + 20, "uv_long");
    cycles(1);
    chk("pg_uv", 32'h1, pg_pin);
    chk("pg_uv_rt", 32'h0, pin_rt);
    chk("pg_uv_nt", 32'h1, pin_nt);
    lockout <= 1'b0;
    gate_wait(1'b1, START, START + 20, "uv_restart");
    cycles(20);
    en_low <= 1'b1;
    gate_wait(1'b0, OFFC, OFFC + 20, "en_off");
    en_low <= 1'b0;
    gate_wait(1'b1, START, START + 20, "en_restart");
    cycles(20);
    {hot, cool} <= 2'b10;
    gate_wait(1'b0, 0, 40, "hot_off");
    cycles(1);
    chk("pg_hot", 32'h1, pg_pin);
    hot <= 1'b0;
    gate_wait(1'b1, START + 30, START + 30, "hyst");
    cool <= 1'b1;
    gate_wait(1'b1, START, START + 20, "cool_restart");
    // Software off acts at once and blocks the start wait until it is cleared.
    apb(1'b1, hsf_pkg::ADDR_CTRL, 32'h1);
    gate_wait(1'b0, 0, 10, "soft_off");
    rdreg(hsf_pkg::ADDR_CTRL, 32'h1, 32'h1, "ctrl_rd");
    rdreg(hsf_pkg::ADDR_STATUS, 32'h7, 32'h0, "soft_off_st");
    apb(1'b1, hsf_pkg::ADDR_CTRL, 32'h0);
    gate_wait(1'b1, START, START + 20, "soft_restart");
    complete_run();
  end
endmodule // hot_swap_fault_sequencer_test
`default_nettype wire
